//--- rtl/bzcc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bzcc_consts.svh"

module bzcc_top
  import bzcc_pkg::*;
#(
  parameter int W         = 16,
  parameter int ALIGN_CYC = `BZCC_ALIGN_CYC
) (
  input  wire logic          CLK_SYS_I,
  input  wire logic          ARST_N_I,
  input  wire logic          CE_I,
  input  wire logic          RUN_I,
  input  wire logic          RUN_SWITCH_I,
  input  wire logic          SPEED_ZERO_I,
  input  wire logic          MOTOR_RESET_EVENT_I,
  input  wire logic          DIR_I,
  input  wire logic          OVER_VOLT_I,
  input  wire logic          OVER_CUR_I,
  input  wire logic [W-1:0]  OVERSPEED_CNT_I,
  input  wire logic [2:0]    PWM_I,
  input  wire logic [2:0]    PWM_N_I,
  input  wire logic          CARRIER_I,
  input  wire logic          DUTY_LOAD_I,
  input  wire logic [W-1:0]  DUTY_I,
  input  wire logic [W-1:0]  DEAD_TIME_I,
  input  wire logic [W-1:0]  WIN_DELAY_I,
  input  wire logic [W-1:0]  WIN_WIDTH_I,
  input  wire logic [W-1:0]  WIN_MIN_I,
  input  wire logic          CMP_RAW_I,
  input  wire logic [W-1:0]  ADVANCE_I,
  input  wire logic [W-1:0]  OL_PERIOD_I,
  input  wire logic [W-1:0]  SPEED_OK_I,
  input  wire logic          ADC_VALID_I,
  input  wire logic [W-1:0]  ADC_DATA_I,
  input  wire logic [W+1:0]  BAL_TOL_I,
  output bzcc_drive_t        DRIVE_O,
  output bzcc_cmp_mux_t      CMP_MUX_O,
  output logic [1:0]         TRIG_SEL_O,
  output logic               WINDOW_O,
  output logic               ADC_TRIG_O,
  output logic               GATED_CMP_O,
  output logic               ZERO_CROSS_O,
  output logic               COMMUTATE_O,
  output logic [2:0]         STEP_O,
  output bzcc_mstate_t       MSTATE_O,
  output logic               FAULT_O,
  output logic [W-1:0]       SPEED_CNT_O
);

  function automatic logic [1:0] hi_ph(input logic [2:0] s);
    case (s)
      3'h0, 3'h1: hi_ph = `BZCC_PH_A;
      3'h2, 3'h3: hi_ph = `BZCC_PH_B;
      default:    hi_ph = `BZCC_PH_C;
    endcase
  endfunction : hi_ph

  function automatic logic [1:0] lo_ph(input logic [2:0] s);
    case (s)
      3'h0, 3'h5: lo_ph = `BZCC_PH_B;
      3'h1, 3'h2: lo_ph = `BZCC_PH_C;
      default:    lo_ph = `BZCC_PH_A;
    endcase
  endfunction : lo_ph

  function automatic logic [1:0] fl_ph(input logic [2:0] s);
    case (s)
      3'h0, 3'h3: fl_ph = `BZCC_PH_C;
      3'h1, 3'h4: fl_ph = `BZCC_PH_B;
      default:    fl_ph = `BZCC_PH_A;
    endcase
  endfunction : fl_ph

  bzcc_mstate_t    mstate;
  bzcc_os_t        os_phase;
  logic [2:0]      step;
  logic [2:0]      next_step;
  logic [31:0]     align_cnt;
  logic [W-1:0]    ol_cnt;
  logic [W-1:0]    free_cnt;
  logic [W-1:0]    last_cap;
  logic [W-1:0]    delta;
  logic [W-1:0]    hist [`BZCC_AVG_DEPTH];
  logic [2:0]      hist_ptr;
  logic [W+2:0]    speed_sum;
  logic [W-1:0]    filt;
  logic [W-1:0]    win_delay;
  logic [W-1:0]    win_width;
  logic [W-1:0]    win_max;
  logic [W-1:0]    win_clamp;
  logic [W-1:0]    os_cnt;
  logic            pwm_prev;
  logic            pwm_cur;
  logic            os_trig;
  logic [W-1:0]    dly_cnt;
  logic            dly_run;
  logic [W-1:0]    dly_load;
  logic [W-1:0]    adv_lim;
  logic [1:0]      blank_cnt;
  logic            gated_d;
  logic            zc;
  logic [2:0]      smp_cnt;
  logic [1:0]      val_cnt;
  logic [W+1:0]    acc;
  logic [W+1:0]    rise_sum;
  logic [W+1:0]    fall_sum;
  logic            rise_ok;
  logic            fall_ok;
  logic            balanced;
  logic            rising;
  logic            ol_expire;
  logic            dly_expire;
  logic            align_done;
  logic            comm;
  logic            stop_event;
  logic            fault_event;
  logic            abort;

  assign stop_event  = (mstate != ROTOR_ALIGN_STATE) && (!RUN_SWITCH_I || SPEED_ZERO_I);
  assign fault_event = OVER_VOLT_I || (OVER_CUR_I && mstate != ROTOR_ALIGN_STATE) ||
                       (OVERSPEED_CNT_I != '0 && filt != '0 && filt < OVERSPEED_CNT_I);
  assign abort       = MOTOR_RESET_EVENT_I || stop_event || fault_event;
  assign align_done  = mstate == ROTOR_ALIGN_STATE && RUN_I && !FAULT_O && !abort &&
                       align_cnt == 32'(ALIGN_CYC - 1);
  assign ol_expire   = mstate == OPEN_START_STATE && ol_cnt >= OL_PERIOD_I;
  assign dly_expire  = dly_run && dly_cnt == '0;
  assign comm        = !abort && (align_done || ol_expire ||
                       (mstate == COMPARATOR_RUN_STATE && dly_expire));
  assign rising      = step[0] == DIR_I;

  always_comb begin
    if (DIR_I) begin
      next_step = (step == `BZCC_STEP_LAST) ? 3'h0 : step + 3'h1;
    end else begin
      next_step = (step == 3'h0) ? `BZCC_STEP_LAST : step - 3'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mstate <= ROTOR_ALIGN_STATE;
    end else if (CE_I) begin
      if (abort) begin
        mstate <= ROTOR_ALIGN_STATE;
      end else begin
        case (mstate)
          ROTOR_ALIGN_STATE: if (align_done) mstate <= OPEN_START_STATE;
          OPEN_START_STATE: begin
            if (ol_expire && balanced && filt != '0 && filt <= SPEED_OK_I) begin
              mstate <= COMPARATOR_RUN_STATE;
            end
          end
          COMPARATOR_RUN_STATE: mstate <= COMPARATOR_RUN_STATE;
          default: mstate <= ROTOR_ALIGN_STATE;
        endcase
      end
    end
  end

  // Alignment timer and the open-loop profile step timer.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      align_cnt <= '0;
      ol_cnt    <= '0;
    end else if (CE_I) begin
      align_cnt <= (mstate == ROTOR_ALIGN_STATE && RUN_I && !FAULT_O && !align_done) ?
                   align_cnt + 32'h1 : '0;
      ol_cnt    <= (comm || mstate != OPEN_START_STATE) ? '0 : ol_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      step <= `BZCC_ALIGN_STEP;
    end else if (CE_I) begin
      if (abort) begin
        step <= `BZCC_ALIGN_STEP;
      end else if (align_done) begin
        step <= `BZCC_FIRST_STEP;
      end else if (comm) begin
        step <= next_step;
      end
    end
  end

  // Fault is sticky until a reset event; a new fault in that cycle wins.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FAULT_O <= 1'b0;
    end else if (CE_I) begin
      FAULT_O <= fault_event || (FAULT_O && !MOTOR_RESET_EVENT_I);
    end
  end

  // Drive, muxes and trigger select follow the step register.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DRIVE_O    <= '0;
      CMP_MUX_O  <= '0;
      TRIG_SEL_O <= '0;
    end else if (CE_I) begin
      DRIVE_O <= '0;
      if (mstate != ROTOR_ALIGN_STATE || (RUN_I && !FAULT_O)) begin
        DRIVE_O.hs[hi_ph(step)]   <= PWM_I[hi_ph(step)];
        DRIVE_O.hs_n[hi_ph(step)] <= PWM_N_I[hi_ph(step)];
        DRIVE_O.ls[lo_ph(step)]   <= 1'b1;
      end
      TRIG_SEL_O        <= hi_ph(step);
      CMP_MUX_O.pos_sel <= rising ? fl_ph(step) : `BZCC_SEL_NEUTRAL;
      CMP_MUX_O.neg_sel <= rising ? `BZCC_SEL_NEUTRAL : fl_ph(step);
    end
  end

  // Window timing set is reloaded with every new duty.
  always_comb begin
    win_max   = W'(((2*W)'(DUTY_I) * (2*W)'(`BZCC_MAX_PCT)) / (2*W)'(`BZCC_PCT_FULL));
    win_max   = (win_max > DEAD_TIME_I) ? win_max - DEAD_TIME_I : '0;
    win_clamp = (WIN_WIDTH_I < WIN_MIN_I) ? WIN_MIN_I : WIN_WIDTH_I;
    win_clamp = (win_clamp > win_max) ? win_max : win_clamp;
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      win_delay <= '0;
      win_width <= '0;
    end else if (CE_I && DUTY_LOAD_I) begin
      win_delay <= WIN_DELAY_I;
      win_width <= win_clamp;
    end
  end

  assign pwm_cur = PWM_I[TRIG_SEL_O];
  assign os_trig = pwm_cur && !pwm_prev;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pwm_prev <= 1'b0;
      os_phase <= OS_IDLE;
      os_cnt   <= '0;
    end else if (CE_I) begin
      pwm_prev <= pwm_cur;
      if (os_trig) begin
        os_phase <= OS_DELAY;
        os_cnt   <= win_delay;
      end else begin
        case (os_phase)
          OS_DELAY: begin
            os_phase <= (os_cnt == '0) ? OS_OPEN : OS_DELAY;
            os_cnt   <= (os_cnt == '0) ? win_width : os_cnt - 1'b1;
          end
          OS_OPEN: begin
            os_phase <= (os_cnt == '0) ? OS_IDLE : OS_OPEN;
            os_cnt   <= (os_cnt == '0) ? '0 : os_cnt - 1'b1;
          end
          default: os_phase <= OS_IDLE;
        endcase
      end
    end
  end

  assign WINDOW_O = os_phase == OS_OPEN;

  // Gated comparator and zero-cross edge, blanked after commutation.
  assign zc = GATED_CMP_O && !gated_d && blank_cnt == '0 && !dly_run &&
              mstate == COMPARATOR_RUN_STATE;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      GATED_CMP_O  <= 1'b0;
      gated_d      <= 1'b0;
      ZERO_CROSS_O <= 1'b0;
      COMMUTATE_O  <= 1'b0;
      blank_cnt    <= '0;
    end else if (CE_I) begin
      GATED_CMP_O  <= CMP_RAW_I && WINDOW_O;
      gated_d      <= GATED_CMP_O;
      ZERO_CROSS_O <= zc;
      COMMUTATE_O  <= comm;
      if (comm) begin
        blank_cnt <= `BZCC_BLANK_PERIODS;
      end else if (CARRIER_I && blank_cnt != '0) begin
        blank_cnt <= blank_cnt - 2'h1;
      end
    end
  end

  // Commutation delay: half a step is 30 degrees, less a limited advance.
  always_comb begin
    adv_lim  = W'(({2'b00, filt} * (W+2)'(`BZCC_ADV_NUM)) / (W+2)'(`BZCC_ADV_DEN));
    dly_load = filt >> 1;
    dly_load = dly_load - ((ADVANCE_I < adv_lim) ? ADVANCE_I : adv_lim);
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dly_cnt <= '0;
      dly_run <= 1'b0;
    end else if (CE_I) begin
      if (abort || comm) begin
        dly_run <= 1'b0;
      end else if (zc) begin
        dly_cnt <= dly_load;
        dly_run <= 1'b1;
      end else if (dly_run) begin
        dly_cnt <= dly_cnt - 1'b1;
      end
    end
  end

  // Free-running capture and the 8-deep moving average.
  assign delta = free_cnt - last_cap;
  assign filt  = W'(speed_sum >> `BZCC_AVG_SHIFT);

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      free_cnt  <= '0;
      last_cap  <= '0;
      hist_ptr  <= '0;
      speed_sum <= '0;
      SPEED_CNT_O <= '0;
      for (int i = 0; i < `BZCC_AVG_DEPTH; i++) hist[i] <= '0;
    end else if (CE_I) begin
      free_cnt    <= free_cnt + 1'b1;
      SPEED_CNT_O <= filt;
      if (comm) begin
        last_cap       <= free_cnt;
        hist[hist_ptr] <= delta;
        hist_ptr       <= hist_ptr + 3'h1;
        speed_sum      <= speed_sum + (W+3)'(delta) - (W+3)'(hist[hist_ptr]);
      end
    end
  end

  // Open-loop converter triggers and rising/falling balance.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ADC_TRIG_O <= 1'b0;
      smp_cnt    <= '0;
    end else if (CE_I) begin
      ADC_TRIG_O <= 1'b0;
      if (comm) begin
        smp_cnt <= '0;
      end else if (mstate == OPEN_START_STATE && os_phase == OS_DELAY && os_cnt == '0 &&
                   ol_cnt >= (OL_PERIOD_I >> 2) + (OL_PERIOD_I >> 3) &&
                   smp_cnt < `BZCC_OL_SAMPLES) begin
        ADC_TRIG_O <= 1'b1;
        smp_cnt    <= smp_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      acc      <= '0;
      val_cnt  <= '0;
      rise_sum <= '0;
      fall_sum <= '0;
      rise_ok  <= 1'b0;
      fall_ok  <= 1'b0;
    end else if (CE_I) begin
      if (mstate != OPEN_START_STATE) begin
        rise_ok <= 1'b0;
        fall_ok <= 1'b0;
      end
      if (comm) begin
        acc     <= '0;
        val_cnt <= '0;
      end else if (ADC_VALID_I && mstate == OPEN_START_STATE) begin
        acc     <= (val_cnt == `BZCC_SMP_LAST) ? '0 : acc + (W+2)'(ADC_DATA_I);
        val_cnt <= val_cnt + 2'h1;
        if (val_cnt == `BZCC_SMP_LAST && rising) begin
          rise_sum <= acc + (W+2)'(ADC_DATA_I);
          rise_ok  <= 1'b1;
        end
        if (val_cnt == `BZCC_SMP_LAST && !rising) begin
          fall_sum <= acc + (W+2)'(ADC_DATA_I);
          fall_ok  <= 1'b1;
        end
      end
    end
  end

  assign balanced = rise_ok && fall_ok && ((rise_sum > fall_sum) ?
                    (rise_sum - fall_sum) : (fall_sum - rise_sum)) <= BAL_TOL_I;
  assign STEP_O   = step;
  assign MSTATE_O = mstate;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  property p_drive_split;
    (DRIVE_O.hs & DRIVE_O.ls) == 3'h0 && $onehot0(DRIVE_O.ls);
  endproperty
  a_drive_split: assert property (p_drive_split) else $error("Bad drive pattern.");

  property p_step_range;
    step <= `BZCC_STEP_LAST;
  endproperty
  a_step_range: assert property (p_step_range) else $error("Step out of range.");

  property p_win_after_delay;
    $rose(WINDOW_O) |-> $past(os_phase) == OS_DELAY && $past(os_cnt) == '0;
  endproperty
  a_win_after_delay: assert property (p_win_after_delay) else $error("Window early.");

  property p_width_clamp;
    CE_I && DUTY_LOAD_I |=> win_width <= $past(win_max);
  endproperty
  a_width_clamp: assert property (p_width_clamp) else $error("Width over max.");

  property p_abort_align;
    CE_I && abort |=> mstate == ROTOR_ALIGN_STATE && step == `BZCC_ALIGN_STEP;
  endproperty
  a_abort_align: assert property (p_abort_align) else $error("No align on abort.");

  property p_cmp_hold;
    CE_I && mstate == COMPARATOR_RUN_STATE && !abort |=> mstate == COMPARATOR_RUN_STATE;
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("Left comparator mode.");

  property p_blank;
    CE_I && comm |=> !zc [*2];
  endproperty
  a_blank: assert property (p_blank) else $error("Zero-cross in blanking.");

  property p_gated_cause;
    zc && $past(CE_I) |-> $past(CMP_RAW_I) && $past(WINDOW_O);
  endproperty
  a_gated_cause: assert property (p_gated_cause) else $error("Ungated zero-cross.");

  property p_delay_comm;
    CE_I && dly_expire && mstate == COMPARATOR_RUN_STATE && !abort |=> step != $past(step);
  endproperty
  a_delay_comm: assert property (p_delay_comm) else $error("Delay did not commutate.");

  property p_fault;
    CE_I && OVER_VOLT_I |=> FAULT_O;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault not raised.");

  c_open: cover property (mstate == ROTOR_ALIGN_STATE ##1 mstate == OPEN_START_STATE);
  c_cmp: cover property (mstate == OPEN_START_STATE ##1 mstate == COMPARATOR_RUN_STATE);
  c_zc_comm: cover property (zc ##[1:200] comm);

endmodule : bzcc_top

`default_nettype wire

//--- rtl/bzcc_consts.svh
`ifndef BZCC_CONSTS_SVH
`define BZCC_CONSTS_SVH

`define BZCC_CLK_MHZ       40
`define BZCC_ALIGN_US      1000
`define BZCC_ALIGN_CYC     (`BZCC_ALIGN_US * `BZCC_CLK_MHZ)
`define BZCC_MAX_PCT       95
`define BZCC_PCT_FULL      100
`define BZCC_ADV_NUM       2
`define BZCC_ADV_DEN       5
`define BZCC_AVG_DEPTH     8
`define BZCC_AVG_SHIFT     3
`define BZCC_OL_SAMPLES    3'h4
`define BZCC_SMP_LAST      2'h3
`define BZCC_BLANK_PERIODS 2'h2
`define BZCC_STEP_LAST     3'h5
`define BZCC_ALIGN_STEP    3'h4
`define BZCC_FIRST_STEP    3'h5
`define BZCC_PH_A          2'h0
`define BZCC_PH_B          2'h1
`define BZCC_PH_C          2'h2
`define BZCC_SEL_NEUTRAL   2'h3

`endif

//--- rtl/bzcc_pkg.sv
package bzcc_pkg;

  typedef enum logic [1:0] {
    ROTOR_ALIGN_STATE,
    OPEN_START_STATE,
    COMPARATOR_RUN_STATE
  } bzcc_mstate_t;

  typedef enum logic [1:0] {
    OS_IDLE,
    OS_DELAY,
    OS_OPEN
  } bzcc_os_t;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] hs_n;
    logic [2:0] ls;
  } bzcc_drive_t;

  typedef struct packed {
    logic [1:0] pos_sel;
    logic [1:0] neg_sel;
  } bzcc_cmp_mux_t;

endpackage : bzcc_pkg

//--- testbench/bzcc_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module bzcc_bridge_model (
  input  wire logic   clk_i,
  input  wire logic   arst_n_i,
  input  wire logic   commutate_i,
  input  wire logic   adc_trig_i,
  output logic        cmp_raw_o,
  output logic        adc_valid_o,
  output logic [15:0] adc_data_o
);
  // The floating winding crosses neutral a fixed time after each step.
  logic [7:0] age;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age <= 8'h00;
    end else if (commutate_i) begin
      age <= 8'h00;
    end else if (age != 8'hFF) begin
      age <= age + 8'h01;
    end
  end
  assign cmp_raw_o = (age >= 8'h14);
  // A conversion answers next cycle; between answers the data bus wanders.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adc_valid_o <= 1'b0;
      adc_data_o  <= 16'h0000;
    end else begin
      adc_valid_o <= adc_trig_i;
      adc_data_o  <= adc_trig_i ? 16'h0200 : ~adc_data_o;
    end
  end
endmodule : bzcc_bridge_model
`default_nettype wire

//--- testbench/bzcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bzcc_top_tb;
  import bzcc_pkg::*;
  logic          clk, arst_n, run, runsw, spdz, rev, dir, ov, oc, car, dld, ce;
  logic          raw, av, win, adct, gated, zc, com, fault, hz, pr;
  logic [2:0]    pwm, pwmn, step;
  logic [1:0]    tsel;
  logic [15:0]   wdel, wwid, wmin, adv, olp, sok, ad, scnt, duty, dead;
  bzcc_drive_t   drv;
  bzcc_cmp_mux_t mux;
  bzcc_mstate_t  mst, pm;
  int            fails, comparisons, seed, ncom, nc, na, wl, cyc, tz, tc, ri, ed, e, f, pc;
  int            dc, de;
  int            sq[$];
  int            wq[$];
  int            ring[8];
  int            hi[6] = '{0, 0, 1, 1, 2, 2};
  int            lo[6] = '{1, 2, 2, 0, 0, 1};
  int            fl[6] = '{2, 1, 0, 2, 1, 0};
  int            wt[3] = '{30, 1, 10};
  int            we[3] = '{18, 6, 11};

  bzcc_top #(.W(16), .ALIGN_CYC(20)) dut (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .RUN_I(run),
    .RUN_SWITCH_I(runsw), .SPEED_ZERO_I(spdz), .MOTOR_RESET_EVENT_I(rev),
    .DIR_I(dir), .OVER_VOLT_I(ov), .OVER_CUR_I(oc), .OVERSPEED_CNT_I(16'h0000),
    .PWM_I(pwm), .PWM_N_I(pwmn), .CARRIER_I(car), .DUTY_LOAD_I(dld),
    .DUTY_I(duty), .DEAD_TIME_I(dead), .WIN_DELAY_I(wdel),
    .WIN_WIDTH_I(wwid), .WIN_MIN_I(wmin), .CMP_RAW_I(raw), .ADVANCE_I(adv),
    .OL_PERIOD_I(olp), .SPEED_OK_I(sok), .ADC_VALID_I(av), .ADC_DATA_I(ad),
    .BAL_TOL_I(18'h00000), .DRIVE_O(drv), .CMP_MUX_O(mux), .TRIG_SEL_O(tsel),
    .WINDOW_O(win), .ADC_TRIG_O(adct), .GATED_CMP_O(gated), .ZERO_CROSS_O(zc),
    .COMMUTATE_O(com), .STEP_O(step), .MSTATE_O(mst), .FAULT_O(fault),
    .SPEED_CNT_O(scnt));

  bzcc_bridge_model bridge (.clk_i(clk), .arst_n_i(arst_n), .commutate_i(com),
    .adc_trig_i(adct), .cmp_raw_o(raw), .adc_valid_o(av), .adc_data_o(ad));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task waitq;
    int t;
    t = 0;
    while (sq.size() > 0 && t < 30000) begin
      @(posedge clk);
      #2;
      t++;
    end
    if (t >= 30000) fails++;
  endtask : waitq

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Motor PWM timer: all phases share one carrier of 40 cycles, 20 active.
  always @(posedge clk) begin
    #2;
    pc = (pc + 1) % 40;
    pwm = (pc < 20) ? 3'h7 : 3'h0;
    pwmn = ~pwm;
    car = (pc == 0);
  end

  always @(posedge clk) begin
    #1;
    cyc++;
    if (arst_n) begin
      chk(gated, pr);
      if (car) nc++;
      if (dc != 0) begin
        chk(drv.ls, 3'h1 << lo[de]);
        chk(drv.hs & ~(3'h1 << hi[de]), 0);
        chk(drv.hs | drv.hs_n, 3'h1 << hi[de]);
        chk(tsel, hi[de]);
        chk({mux.pos_sel == fl[de], mux.neg_sel == 2'h3}, {2{mux.pos_sel == fl[de]}});
        chk((mux.pos_sel == fl[de]) || (mux.neg_sel == fl[de]), 1);
        dc = 0;
      end
      if (com && mst != ROTOR_ALIGN_STATE) begin
        e = (sq.size() > 0) ? sq.pop_front() : 7;
        chk(step, e);
        dc = 1;
        de = e;
        if (pm == OPEN_START_STATE) chk(na, 4);
        if (pm == COMPARATOR_RUN_STATE) begin
          chk({hz, 31'(cyc - tz)}, {1'b1, 31'(ed + 1)});
        end
        ring[ri] = cyc - tc;
        ri = (ri + 1) % 8;
        tc = cyc;
        {na, nc, hz, pm} = {32'h0, 32'h0, 1'b0, mst};
        ncom++;
      end
      if (adct) na++;
      if (zc) begin
        chk(nc >= 2, 1);
        f = 0;
        foreach (ring[i]) f += ring[i];
        f = f >> 3;
        chk(scnt, f);
        ed = f / 2 - ((adv < f * 2 / 5) ? adv : f * 2 / 5);
        tz = cyc;
        hz = 1'b1;
      end
      if (mst == ROTOR_ALIGN_STATE) pm = mst;
      if (win) wl++;
      else if (wl > 0) begin
        if (wq.size() > 0) chk(wl, wq.pop_front());
        wl = 0;
      end
    end
    pr = raw & win;
  end

  initial begin
    #(25 * 80000);
    fails++;
    results();
  end

  initial begin
    {fails, comparisons, ncom, nc, na, wl, cyc, tz, tc, ri, pc, dc, de} = '0;
    {ce, duty, dead, pwmn} = {1'b1, 16'h0014, 16'h0002, 3'h7};
    {hz, pr, car, pwm, pm} = '0;
    seed = 32'hfef5e2d9;
    {arst_n, run, spdz, rev, ov, oc, dld, adv, sok} = '0;
    {runsw, dir, wdel, wwid, wmin, olp} = {1'b1, 1'b1, 16'h1, 16'h8, 16'h2, 16'h190};
    repeat (5) @(posedge clk);
    #2 arst_n = 1'b1;
    @(posedge clk);
    #2;
    chk({step, mst, fault}, {3'h4, ROTOR_ALIGN_STATE, 1'b0});
    {ce, ov} = 2'b01;
    repeat (3) @(posedge clk);
    #2 {ce, ov} = 2'b10;
    chk({fault, step, mst}, {1'b0, 3'h4, ROTOR_ALIGN_STATE});
    for (int i = 0; i < 3; i++) begin
      do @(posedge clk); while (pc != 30);
      #2;
      {wwid, wmin, wdel, dld} = {wt[i][15:0], 16'h5, 16'($random(seed) & 3), 1'b1};
      wq.push_back(we[i]);
      @(posedge clk);
      #2 dld = 1'b0;
    end
    repeat (80) @(posedge clk);
    #2;
    chk(wq.size(), 0);
    $display("test window done");
    for (int i = 0; i < 12; i++) sq.push_back((5 + i) % 6);
    run = 1'b1;
    waitq();
    chk(mst, OPEN_START_STATE);
    sok = 16'hFFFF;
    for (int i = 0; i < 18; i++) sq.push_back((5 + i) % 6);
    waitq();
    chk(mst, COMPARATOR_RUN_STATE);
    adv = 16'hFFFF;
    for (int i = 0; i < 8; i++) sq.push_back((5 + i) % 6);
    waitq();
    adv = 16'h0000;
    $display("test run done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) runsw = 1'b0;
      else spdz = 1'b1;
      repeat (2) @(posedge clk);
      #2;
      chk({step, mst}, {3'h4, ROTOR_ALIGN_STATE});
      {runsw, spdz, dir} = {1'b1, 1'b0, k[0]};
      for (int i = 0; i < 8; i++) sq.push_back(dir ? (5 + i) % 6 : (11 - i) % 6);
      waitq();
    end
    $display("test stop done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) ov = 1'b1;
      else oc = 1'b1;
      repeat (2) @(posedge clk);
      #2 {ov, oc} = 2'b00;
      @(posedge clk);
      #2;
      chk({fault, step, mst}, {1'b1, 3'h4, ROTOR_ALIGN_STATE});
      rev = 1'b1;
      @(posedge clk);
      #2 rev = 1'b0;
      @(posedge clk);
      #2;
      chk(fault, 0);
      for (int i = 0; i < 4; i++) sq.push_back(dir ? (5 + i) % 6 : (11 - i) % 6);
      waitq();
    end
    $display("test fault done");
    results();
  end
endmodule : bzcc_top_tb
`default_nettype wire
